// >>> design/sfm_defines.svh
// Purpose: Named constants of the serial flash mode and command logic
// Assumes: Included by its bare name wherever a constant is needed
// Notes: Definitions only
`ifndef SFM_DEFINES_SVH
`define SFM_DEFINES_SVH
`define SFM_OP_SEC_RD      8'h48
`define SFM_OP_SET_PARAM   8'hc0
`define SFM_OP_WRAP_RD     8'h0c
`define SFM_OP_FAST_RD     8'h0b
`define SFM_OP_QUAD_ON     8'h38
`define SFM_OP_QUAD_OFF    8'hff
`define SFM_OP_RST_EN      8'h66
`define SFM_OP_RST         8'h99
`define SFM_OP_UDPD        8'h79
`define SFM_OP_BITS        6'h08
`define SFM_ADDR_BITS      6'h18
`define SFM_PARAM_BITS     6'h08
`define SFM_SEC_DUMMY      4'h8
`define SFM_BLANK          8'hff
`define SFM_SEC_HI         8'h00
`define SFM_SEC_TOP        2'h0
`define SFM_SEC_NONE       2'h0
`define SFM_SEC_MID        4'h0
`define SFM_SEC_ENTRIES    10'h300
`define SFM_PARAM_RST      8'h00
`define SFM_DUMMY_MSB      5
`define SFM_DUMMY_LSB      4
`define SFM_WRAP_MSB       1
`define SFM_WRAP_LSB       0
`define SFM_DUMMY_BASE     4'h2
`define SFM_WRAP_BASE      7'h08
`define SFM_REG_CTRL       8'h00
`define SFM_REG_STATUS     8'h04
`define SFM_REG_SEC_ADDR   8'h08
`define SFM_REG_SEC_DATA   8'h0c
`define SFM_CTRL_QE        0
`define SFM_CTRL_WEL       1
`define SFM_CTRL_SUS       2
`define SFM_CTRL_DPD       3
`define SFM_CLK_NS         5
`define SFM_T_RESET_NS     28000
`define SFM_T_ENTER_NS     3000
`define SFM_T_EXIT_NS      10000
`define SFM_T_CS_WAKE_NS   20
`endif

// >>> design/sfm_pkg.sv
// Purpose: Types of the serial flash mode and command logic
// Assumes: Constants come from sfm_defines.svh
// Notes: APB request and answer travel as packed structs
package sfm_pkg;
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} sfm_apb_req_t;
	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} sfm_apb_rsp_t;
	typedef enum logic [5:0] {
		PH_CMD   = 6'h01,
		PH_ADDR  = 6'h02,
		PH_PARAM = 6'h04,
		PH_DUMMY = 6'h08,
		PH_DATA  = 6'h10,
		PH_SKIP  = 6'h20
	} sfm_phase_t;
	typedef enum logic [4:0] {
		PW_STBY  = 5'h01,
		PW_DPD   = 5'h02,
		PW_ENTER = 5'h04,
		PW_UDPD  = 5'h08,
		PW_EXIT  = 5'h10
	} sfm_power_t;
endpackage

// >>> design/sfm_flash_cmd.sv
// Purpose: Flash command logic: security read, parameters, wrap, quad mode, reset, power-down
// Assumes: Link pins sampled by the 200 MHz clock, registers over APB
// Notes: Main array storage lives outside, reached by array_addr/array_data
//
// What this block does
// - Security read is 48h, 24-bit address, eight dummy clocks, then data.
// - Opcode and address taken on rising clock, data out on falling, MSB first.
// - Security read byte address increments and wraps FFh to 00h until select rises.
// - Address must match register one to three layout, otherwise every byte reads FFh.
// - Security read while busy is ignored without disturbing the running operation.
// - C0h accepted only in quad command mode, rejected in serial mode.
// - Dummy field codes 00..11 give 2, 4, 6 or 8 dummy clocks.
// - Wrap field codes 00..11 give 8, 16, 32 or 64 byte wrap length.
// - Power-up and reset give 8-byte wrap and two dummy clocks.
// - Wrapped burst reads like fast read but wraps inside aligned window.
// - Serial mode at power-up; 38h enters quad mode only with quad enable set.
// - Entering quad mode keeps write latch and suspend, resets wrap length.
// - FFh leaves quad mode, keeping write latch, suspend and wrap length.
// - Reset only when 66h directly followed by 99h; anything else disarms.
// - Reset aborts operations, clears write latch, suspend and read parameters.
// - After reset about 28 us pass while every instruction is rejected.
// - 79h in deep power-down enters ultra-deep power-down after select rises.
// - Select must rise after whole opcode on byte boundary, else back to standby.
// - Ultra-deep power-down ignores everything; 79h ignored while busy.
// - Wake by select low for minimum time; ops begun before standby ignored.
`timescale 1ns/1ps
`include "sfm_defines.svh"

module sfm_flash_cmd
	import sfm_pkg::*;
#(
	parameter int RESET_CYC = (`SFM_T_RESET_NS + `SFM_CLK_NS - 1) / `SFM_CLK_NS
) (
	input  wire logic         clock,
	input  wire logic         rst,
	input  wire sfm_apb_req_t apb_req,
	output sfm_apb_rsp_t      apb_rsp,
	input  wire logic         select_n,
	input  wire logic         sclk,
	input  wire logic [3:0]   io_in,
	output logic [3:0]        io_out,
	output logic [3:0]        io_oe_n,
	input  wire logic         op_busy,
	input  wire logic [7:0]   array_data,
	output logic [23:0]       array_addr,
	output logic              array_rd,
	output logic              abort_op
);
	localparam int ENTER_RAW = `SFM_T_ENTER_NS / `SFM_CLK_NS;
	localparam int EXIT_RAW  = `SFM_T_EXIT_NS / `SFM_CLK_NS;
	localparam int WAKE_RAW  = (`SFM_T_CS_WAKE_NS + `SFM_CLK_NS - 1) / `SFM_CLK_NS;
	localparam logic [11:0] ENTER_CYC = 12'((ENTER_RAW < 1) ? 1 : ENTER_RAW);
	localparam logic [11:0] EXIT_CYC  = 12'((EXIT_RAW < 1) ? 1 : EXIT_RAW);
	localparam logic [11:0] WAKE_CYC  = 12'((WAKE_RAW < 1) ? 1 : WAKE_RAW);

	if (RESET_CYC < 1 || RESET_CYC > 65535) begin : g_chk_rst
		$error("RESET_CYC out of range");
	end
	if (ENTER_RAW > 4095 || EXIT_RAW > 4095 || WAKE_RAW > 4095) begin : g_chk_pw
		$error("Power timing count too large");
	end

	logic              cs_s1, cs_s2, cs_s3, ck_s1, ck_s2, ck_s3;
	logic [3:0]        io_s1, io_s2;
	logic              rise, fall, cs_fall, cs_rise;
	sfm_phase_t        phase, next_phase;
	sfm_power_t        pw, next_pw;
	logic [5:0]        cnt, next_cnt;
	logic [2:0]        bits, next_bits;
	logic [31:0]       sh, next_sh;
	logic [7:0]        cmd, next_cmd;
	logic [23:0]       addr, next_addr;
	logic [3:0]        dtgt, next_dtgt;
	logic [2:0]        oidx, next_oidx;
	logic [3:0]        io_q, next_io, oe_n, next_oe_n;
	logic              quad, next_quad;
	logic [7:0]        param, next_param;
	logic              armed, next_armed, pend, next_pend;
	logic [11:0]       pcnt, next_pcnt;
	logic [15:0]       rcnt, next_rcnt;
	logic              abort, next_abort, qe, next_qe;
	logic              write_latch_flag, next_wel, suspend_flag, next_sus;
	logic [9:0]        sec_addr, next_sec_addr;
	logic [31:0]       rdata, next_rdata;
	logic [7:0]        sec_mem [0:767];
	logic [31:0]       sh_in;
	logic [5:0]        step, cnt_in;
	logic [7:0]        op, dbyte, sec_rd, apb_sec_rd;
	logic [9:0]        sec_idx;
	logic [6:0]        wrap_mask;
	logic              sec_hit, last_out, setup, acc, mapped, wr, dpd_req, mem_we;

	// Two-stage synchronisers on every link pin
	always_ff @(posedge clock) begin
		cs_s1 <= select_n;
		cs_s2 <= cs_s1;
		cs_s3 <= cs_s2;
		ck_s1 <= sclk;
		ck_s2 <= ck_s1;
		ck_s3 <= ck_s2;
		io_s1 <= io_in;
		io_s2 <= io_s1;
	end

	assign rise    = ck_s2 & ~ck_s3 & ~cs_s2;
	assign fall    = ~ck_s2 & ck_s3 & ~cs_s2;
	assign cs_fall = ~cs_s2 & cs_s3;
	assign cs_rise = cs_s2 & ~cs_s3;
	assign step      = quad ? 6'h4 : 6'h1;
	assign cnt_in    = cnt + step;
	assign sh_in     = quad ? {sh[27:0], io_s2} : {sh[30:0], io_s2[0]};
	assign op        = sh_in[7:0];
	assign wrap_mask = (`SFM_WRAP_BASE << param[`SFM_WRAP_MSB:`SFM_WRAP_LSB]) - 7'h1;
	assign sec_hit   = addr[23:16] == `SFM_SEC_HI && addr[15:14] == `SFM_SEC_TOP
		&& addr[13:12] != `SFM_SEC_NONE && addr[11:8] == `SFM_SEC_MID;
	assign sec_idx   = {addr[13:12] - 2'h1, addr[7:0]};
	assign sec_rd    = sec_mem[sec_idx];
	assign dbyte     = (cmd == `SFM_OP_SEC_RD) ? (sec_hit ? sec_rd : `SFM_BLANK) : array_data;
	assign last_out  = quad ? (oidx == 3'h1) : (oidx == 3'h7);

	always_comb begin
		next_phase = phase;
		next_cnt   = cnt;
		next_bits  = bits;
		next_sh    = sh;
		next_cmd   = cmd;
		next_addr  = addr;
		next_dtgt  = dtgt;
		next_oidx  = oidx;
		next_io    = io_q;
		next_oe_n  = oe_n;
		next_quad  = quad;
		next_param = param;
		next_armed = armed;
		next_pend  = pend;
		next_pw    = pw;
		next_pcnt  = pcnt;
		next_rcnt  = rcnt;
		next_abort = 1'b0;
		if (rcnt != 16'h0)
			next_rcnt = rcnt - 16'h1;
		unique case (pw)
			PW_STBY: if (dpd_req)
				next_pw = PW_DPD;
			PW_DPD: ;
			PW_ENTER: begin
				if (pcnt <= 12'h1)
					next_pw = PW_UDPD;
				else
					next_pcnt = pcnt - 12'h1;
			end
			PW_UDPD: if (!cs_s2 && pcnt < WAKE_CYC)
				next_pcnt = pcnt + 12'h1;
			PW_EXIT: begin
				if (pcnt <= 12'h1)
					next_pw = PW_STBY;
				else
					next_pcnt = pcnt - 12'h1;
			end
		endcase
		if (cs_fall) begin
			next_cnt  = 6'h0;
			next_bits = 3'h0;
			next_oidx = 3'h0;
			next_oe_n = 4'hf;
			next_pend = 1'b0;
			if (rcnt != 16'h0 || pw == PW_ENTER || pw == PW_UDPD || pw == PW_EXIT)
				next_phase = PH_SKIP;
			else
				next_phase = PH_CMD;
			if (pw == PW_UDPD)
				next_pcnt = 12'h0;
		end
		if (rise) begin
			next_bits = bits + step[2:0];
			unique case (phase)
				PH_CMD: begin
					next_sh  = sh_in;
					next_cnt = cnt_in;
					if (cnt_in == `SFM_OP_BITS) begin
						next_cmd   = op;
						next_cnt   = 6'h0;
						next_phase = PH_SKIP;
						next_armed = (op == `SFM_OP_RST_EN) && pw == PW_STBY;
						if (armed && op == `SFM_OP_RST) begin
							next_quad  = 1'b0;
							next_param = `SFM_PARAM_RST;
							next_abort = 1'b1;
							next_rcnt  = 16'(RESET_CYC);
						end else if (pw == PW_DPD) begin
							if (op == `SFM_OP_UDPD && !op_busy)
								next_pend = 1'b1;
						end else begin
							unique case (op)
								`SFM_OP_SEC_RD: if (!quad && !op_busy)
									next_phase = PH_ADDR;
								`SFM_OP_SET_PARAM: if (quad)
									next_phase = PH_PARAM;
								`SFM_OP_WRAP_RD, `SFM_OP_FAST_RD: if (quad)
									next_phase = PH_ADDR;
								`SFM_OP_QUAD_ON: begin
									if (!quad && qe) begin
										next_quad = 1'b1;
										next_param[`SFM_WRAP_MSB:`SFM_WRAP_LSB] =
											2'(`SFM_PARAM_RST);
									end
								end
								`SFM_OP_QUAD_OFF: if (quad)
									next_quad = 1'b0;
								default: ;
							endcase
						end
					end
				end
				PH_ADDR: begin
					next_sh  = sh_in;
					next_cnt = cnt_in;
					if (cnt_in == `SFM_ADDR_BITS) begin
						next_addr  = sh_in[23:0];
						next_cnt   = 6'h0;
						next_phase = PH_DUMMY;
						if (cmd == `SFM_OP_SEC_RD)
							next_dtgt = `SFM_SEC_DUMMY;
						else
							next_dtgt = {1'b0, param[`SFM_DUMMY_MSB:`SFM_DUMMY_LSB], 1'b0}
								+ `SFM_DUMMY_BASE;
					end
				end
				PH_DUMMY: begin
					next_cnt = cnt + 6'h1;
					if (cnt[3:0] + 4'h1 == dtgt) begin
						next_phase = PH_DATA;
						next_oidx  = 3'h0;
					end
				end
				PH_PARAM: begin
					next_sh  = sh_in;
					next_cnt = cnt_in;
					if (cnt_in == `SFM_PARAM_BITS) begin
						next_param = sh_in[7:0];
						next_phase = PH_SKIP;
					end
				end
				PH_DATA, PH_SKIP: ;
			endcase
		end
		if (fall && phase == PH_DATA) begin
			if (quad) begin
				next_io   = (oidx == 3'h0) ? dbyte[7:4] : dbyte[3:0];
				next_oe_n = 4'h0;
			end else begin
				next_io   = {2'h0, dbyte[3'h7 - oidx], 1'b0};
				next_oe_n = 4'hd;
			end
			next_oidx = oidx + 3'h1;
			if (last_out) begin
				next_oidx = 3'h0;
				if (cmd == `SFM_OP_SEC_RD)
					next_addr = {addr[23:8], addr[7:0] + 8'h1};
				else if (cmd == `SFM_OP_WRAP_RD)
					next_addr = (addr & ~{17'h0, wrap_mask})
						| ((addr + 24'h1) & {17'h0, wrap_mask});
				else
					next_addr = addr + 24'h1;
			end
		end
		if (cs_rise) begin
			next_phase = PH_SKIP;
			next_oe_n  = 4'hf;
			next_pend  = 1'b0;
			if (pend) begin
				if (bits == 3'h0) begin
					next_pw   = PW_ENTER;
					next_pcnt = ENTER_CYC;
				end else
					next_pw = PW_STBY;
			end
			if (pw == PW_UDPD && pcnt >= WAKE_CYC) begin
				next_pw   = PW_EXIT;
				next_pcnt = EXIT_CYC;
			end
		end
		if (next_abort)
			next_pw = PW_STBY;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			phase <= PH_SKIP;
			cnt   <= 6'h0;
			bits  <= 3'h0;
			sh    <= 32'h0;
			cmd   <= 8'h0;
			addr  <= 24'h0;
			dtgt  <= `SFM_SEC_DUMMY;
			oidx  <= 3'h0;
			io_q  <= 4'h0;
			oe_n  <= 4'hf;
			quad  <= 1'b0;
			param <= `SFM_PARAM_RST;
			armed <= 1'b0;
			pend  <= 1'b0;
			pw    <= PW_STBY;
			pcnt  <= 12'h0;
			rcnt  <= 16'h0;
			abort <= 1'b0;
		end else begin
			phase <= next_phase;
			cnt   <= next_cnt;
			bits  <= next_bits;
			sh    <= next_sh;
			cmd   <= next_cmd;
			addr  <= next_addr;
			dtgt  <= next_dtgt;
			oidx  <= next_oidx;
			io_q  <= next_io;
			oe_n  <= next_oe_n;
			quad  <= next_quad;
			param <= next_param;
			armed <= next_armed;
			pend  <= next_pend;
			pw    <= next_pw;
			pcnt  <= next_pcnt;
			rcnt  <= next_rcnt;
			abort <= next_abort;
		end
	end

	assign io_out     = io_q;
	assign io_oe_n    = oe_n;
	assign array_addr = addr;
	assign array_rd   = (phase == PH_DATA) && (cmd != `SFM_OP_SEC_RD);
	assign abort_op   = abort;
	// APB slave, zero wait states
	assign setup   = apb_req.psel & ~apb_req.penable;
	assign acc     = apb_req.psel & apb_req.penable;
	assign mapped  = apb_req.paddr == `SFM_REG_CTRL || apb_req.paddr == `SFM_REG_STATUS
		|| apb_req.paddr == `SFM_REG_SEC_ADDR || apb_req.paddr == `SFM_REG_SEC_DATA;
	assign wr      = acc & apb_req.pwrite & mapped;
	assign dpd_req = wr && apb_req.paddr == `SFM_REG_CTRL && apb_req.pwdata[`SFM_CTRL_DPD];
	assign mem_we  = wr && apb_req.paddr == `SFM_REG_SEC_DATA && sec_addr < `SFM_SEC_ENTRIES;
	assign apb_sec_rd = (sec_addr < `SFM_SEC_ENTRIES) ? sec_mem[sec_addr] : `SFM_BLANK;
	assign apb_rsp = '{prdata: rdata, pready: 1'b1, pslverr: acc & ~mapped};

	always_comb begin
		next_qe       = qe;
		next_wel      = write_latch_flag;
		next_sus      = suspend_flag;
		next_sec_addr = sec_addr;
		next_rdata    = rdata;
		if (wr && apb_req.paddr == `SFM_REG_CTRL) begin
			next_qe  = apb_req.pwdata[`SFM_CTRL_QE];
			next_wel = apb_req.pwdata[`SFM_CTRL_WEL];
			next_sus = apb_req.pwdata[`SFM_CTRL_SUS];
		end
		if (wr && apb_req.paddr == `SFM_REG_SEC_ADDR)
			next_sec_addr = apb_req.pwdata[9:0];
		if (abort) begin
			next_wel = 1'b0;
			next_sus = 1'b0;
		end
		if (setup && !apb_req.pwrite) begin
			unique case (apb_req.paddr)
				`SFM_REG_CTRL:     next_rdata = {29'h0, suspend_flag, write_latch_flag, qe};
				`SFM_REG_STATUS:   next_rdata = {16'h0, param, armed, rcnt != 16'h0, pw, quad};
				`SFM_REG_SEC_ADDR: next_rdata = {22'h0, sec_addr};
				`SFM_REG_SEC_DATA: next_rdata = {24'h0, apb_sec_rd};
				default:           next_rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			qe       <= 1'b0;
			write_latch_flag      <= 1'b0;
			suspend_flag      <= 1'b0;
			sec_addr <= 10'h0;
			rdata    <= 32'h0;
		end else begin
			qe       <= next_qe;
			write_latch_flag      <= next_wel;
			suspend_flag      <= next_sus;
			sec_addr <= next_sec_addr;
			rdata    <= next_rdata;
		end
	end

	// Security register storage, loaded by software
	always_ff @(posedge clock) begin
		if (mem_we)
			sec_mem[sec_addr] <= apb_req.pwdata[7:0];
	end
endmodule // sfm_flash_cmd

// >>> verification/sfm_flash_cmd_chk.sv
// Purpose: Assertions on the ports of sfm_flash_cmd
// Assumes: One clock domain, rst synchronous active high
// Notes: Attached by the bind below
`timescale 1ns/1ps
module sfm_flash_cmd_chk
	import sfm_pkg::*;
#(
	parameter int RESET_CYC = 5600
) (
	input wire logic         clock,
	input wire logic         rst,
	input wire sfm_apb_req_t apb_req,
	input wire sfm_apb_rsp_t apb_rsp,
	input wire logic         select_n,
	input wire logic [3:0]   io_oe_n,
	input wire logic         array_rd,
	input wire logic         abort_op
);
	logic acc;
	logic rd_setup;
	logic [15:0] rec_cnt, next_rec_cnt;
	assign acc = apb_req.psel && apb_req.penable;
	assign rd_setup = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
	// Cycles left of reset recovery, restarted by each accepted reset
	always_comb begin
		next_rec_cnt = rec_cnt;
		if (abort_op)
			next_rec_cnt = 16'(RESET_CYC);
		else if (rec_cnt != 16'h0)
			next_rec_cnt = rec_cnt - 16'h1;
	end
	always_ff @(posedge clock) begin
		if (rst)
			rec_cnt <= 16'h0;
		else
			rec_cnt <= next_rec_cnt;
	end
	default clocking @(posedge clock);
	endclocking
	default disable iff (rst);
	a_apb_ready: assert property (acc |-> apb_rsp.pready)
		else $error("pready low in access");
	a_slverr_map: assert property (acc |-> apb_rsp.pslverr
		== !(apb_req.paddr inside {8'h00, 8'h04, 8'h08, 8'h0c})) else $error("pslverr wrong");
	a_prdata_hold: assert property (!rd_setup |=> $stable(apb_rsp.prdata))
		else $error("prdata changed without read");
	a_oe_idle: assert property (select_n [*8] |-> io_oe_n == 4'hf && !array_rd)
		else $error("drive outside frame");
	a_oe_code: assert property (io_oe_n inside {4'hf, 4'hd, 4'h0})
		else $error("bad enable pattern");
	a_recover_quiet: assert property (rec_cnt != 16'h0 |-> io_oe_n == 4'hf)
		else $error("drive during reset recovery");
	a_quad_source: assert property (io_oe_n == 4'h0 |-> array_rd)
		else $error("quad data without array read");
	a_abort_pulse: assert property (abort_op |=> !abort_op)
		else $error("abort longer than one cycle");
	a_abort_quiet: assert property (abort_op |-> io_oe_n == 4'hf && !array_rd)
		else $error("drive during abort");
	a_reset_state: assert property ($past(rst) |-> io_oe_n == 4'hf && !abort_op
		&& !array_rd && apb_rsp.prdata == 32'h0) else $error("bad state after reset");
endmodule // sfm_flash_cmd_chk

bind sfm_flash_cmd sfm_flash_cmd_chk #(.RESET_CYC(RESET_CYC)) u_chk (
	.clock    (clock),
	.rst      (rst),
	.apb_req  (apb_req),
	.apb_rsp  (apb_rsp),
	.select_n (select_n),
	.io_oe_n  (io_oe_n),
	.array_rd (array_rd),
	.abort_op (abort_op)
);

// >>> verification/sfm_host_model.sv
// Purpose: Serial host controller on the flash link
// Assumes: sclk idles low, 80 ns period, any number of sclk cycles per frame
// Notes: Tasks are called from the bench
`timescale 1ns/1ps
module sfm_host_model (
	input  wire logic       clock,
	output logic            select_n,
	output logic            sclk,
	output logic [3:0]      io_in,
	input  wire logic [3:0] io_out,
	input  wire logic [3:0] io_oe_n
);
	logic       quad;
	logic [3:0] drv;
	// Device drive wins where enabled
	assign io_in = (io_oe_n & drv) | (~io_oe_n & io_out);
	initial begin
		select_n = 1'b1;
		sclk = 1'b0;
		drv = 4'h0;
		quad = 1'b0;
	end
	task automatic open_frame();
		select_n <= 1'b0;
		repeat (4) @(posedge clock);
	endtask
	// One bit or nibble per sclk cycle, read just before the rising edge
	task automatic xfer(input logic [7:0] b, input int n, output logic [7:0] q);
		for (int i = 0; i < n; i++) begin
			if (quad) drv <= i[0] ? b[3:0] : b[7:4];
			else drv <= {~drv[3:1], b[7 - i]};
			sclk <= 1'b0;
			repeat (8) @(posedge clock);
			q = quad ? {q[3:0], io_in} : {q[6:0], io_in[1]};
			sclk <= 1'b1;
			repeat (8) @(posedge clock);
		end
	endtask
	task automatic close_frame();
		sclk <= 1'b0;
		repeat (8) @(posedge clock);
		select_n <= 1'b1;
		drv <= ~drv;
		repeat (16) @(posedge clock);
	endtask
endmodule // sfm_host_model

// >>> verification/tb_top.sv
// Purpose: Self-checking bench for sfm_flash_cmd
// Assumes: Host model drives the link, bench drives APB
// Notes: Reset recovery shortened to 400 clocks
`timescale 1ns/1ps
`include "sfm_defines.svh"
module tb_top
	import sfm_pkg::*;
;
	logic         clock, rst, op_busy, array_rd, abort_op;
	logic         select_n, sclk, drove, aborted, er;
	sfm_apb_req_t apb_req;
	sfm_apb_rsp_t apb_rsp;
	logic [3:0]   io_in, io_out, io_oe_n;
	logic [23:0]  array_addr;
	logic [7:0]   array_data, r;
	logic [7:0]   rb [4];
	logic [31:0]  q;
	int           n_errors, n_checks, cyc, k, i, wl;
	assign array_data = array_addr[7:0] ^ 8'h5a;
	sfm_flash_cmd #(.RESET_CYC(400)) dut (
		.clock(clock), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
		.select_n(select_n), .sclk(sclk), .io_in(io_in), .io_out(io_out),
		.io_oe_n(io_oe_n), .op_busy(op_busy), .array_data(array_data),
		.array_addr(array_addr), .array_rd(array_rd), .abort_op(abort_op));
	sfm_host_model host (.clock(clock), .select_n(select_n), .sclk(sclk),
		.io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n));
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		chk_word({24'h0, got}, {24'h0, exp});
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		apb_req <= '{1'b1, 1'b0, wr, a, d};
		@(posedge clock);
		apb_req.penable <= 1'b1;
		do @(posedge clock); while (apb_rsp.pready !== 1'b1);
		q = apb_rsp.prdata;
		er = apb_rsp.pslverr;
		apb_req <= '0;
		@(posedge clock);
	endtask
	// Status: params, armed and busy, power state, quad mode
	task automatic rs(input logic [7:0] p, input logic [1:0] ab, input logic [4:0] pw,
		input logic qm);
		apb(1'b0, `SFM_REG_STATUS, 32'h0);
		chk_word(q, {16'h0, p, ab, pw, qm});
	endtask
	task automatic frame(input logic [7:0] op, input logic [23:0] a, input int na, nd, nr);
		int w;
		w = host.quad ? 2 : 8;
		host.open_frame();
		host.xfer(op, w, r);
		for (int j = 0; j < na; j++) host.xfer(a[23 - 8 * j -: 8], w, r);
		if (nd > 0) host.xfer(8'h00, nd, r);
		for (int j = 0; j < nr; j++) begin
			host.xfer(8'h00, w, r);
			rb[j] = r;
		end
		host.close_frame();
	endtask
	always #2.5 clock = ~clock;
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (io_oe_n !== 4'hf) drove <= 1'b1;
		if (abort_op === 1'b1) aborted <= 1'b1;
		if (cyc == 40000) begin
			n_errors++;
			tally_and_finish();
		end
	end
	initial begin
		clock = 1'b0;
		rst = 1'b1;
		apb_req = '0;
		op_busy = 1'b0;
		{n_errors, n_checks, cyc, drove, aborted} = '0;
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		repeat (4) @(posedge clock);
		rs(8'h00, 2'h0, 5'h01, 1'b0);
		apb(1'b0, 8'h10, 32'h0);
		chk_word({31'h0, er}, 32'h1);
		$display("test reset_state done");
		for (k = 1; k < 5; k++) begin
			apb(1'b1, `SFM_REG_SEC_ADDR, 32'(k * 256 - 1));
			apb(1'b1, `SFM_REG_SEC_DATA, 32'(192 + k));
			apb(1'b1, `SFM_REG_SEC_ADDR, 32'(k * 256 - 256));
			apb(1'b1, `SFM_REG_SEC_DATA, 32'(208 + k));
			frame(`SFM_OP_SEC_RD, {8'h00, 4'(k), 12'h0ff}, 3, 8, 2);
			chk_byte(rb[0], k < 4 ? 8'(192 + k) : 8'hff);
			chk_byte(rb[1], k < 4 ? 8'(208 + k) : 8'hff);
		end
		frame(`SFM_OP_SEC_RD, 24'h0110ff, 3, 8, 1);
		chk_byte(rb[0], 8'hff);
		op_busy <= 1'b1;
		drove = 1'b0;
		frame(`SFM_OP_SEC_RD, 24'h0010ff, 3, 8, 1);
		chk_word({31'h0, drove}, 32'h0);
		op_busy <= 1'b0;
		$display("test security_read done");
		frame(`SFM_OP_SET_PARAM, 24'h330000, 1, 0, 0);
		frame(`SFM_OP_QUAD_ON, 24'h0, 0, 0, 0);
		rs(8'h00, 2'h0, 5'h01, 1'b0);
		apb(1'b1, `SFM_REG_CTRL, 32'h3);
		frame(`SFM_OP_QUAD_ON, 24'h0, 0, 0, 0);
		host.quad = 1'b1;
		rs(8'h00, 2'h0, 5'h01, 1'b1);
		for (k = 0; k < 4; k++) begin
			wl = 8 << k;
			frame(`SFM_OP_SET_PARAM, {2'h0, 2'(k), 2'h0, 2'(k), 16'h0}, 1, 0, 0);
			rs({2'h0, 2'(k), 2'h0, 2'(k)}, 2'h0, 5'h01, 1'b1);
			frame(`SFM_OP_WRAP_RD, 24'(320 + wl - 2), 3, 2 + 2 * k, 4);
			for (i = 0; i < 4; i++) chk_byte(rb[i], 8'(64 + (wl - 2 + i) % wl) ^ 8'h5a);
		end
		frame(`SFM_OP_FAST_RD, 24'h00017e, 3, 8, 4);
		for (i = 0; i < 4; i++) chk_byte(rb[i], 8'(126 + i) ^ 8'h5a);
		frame(`SFM_OP_QUAD_OFF, 24'h0, 0, 0, 0);
		host.quad = 1'b0;
		rs(8'h33, 2'h0, 5'h01, 1'b0);
		frame(`SFM_OP_QUAD_ON, 24'h0, 0, 0, 0);
		host.quad = 1'b1;
		rs(8'h30, 2'h0, 5'h01, 1'b1);
		apb(1'b0, `SFM_REG_CTRL, 32'h0);
		chk_word(q, 32'h3);
		$display("test quad_mode done");
		frame(`SFM_OP_RST_EN, 24'h0, 0, 0, 0);
		rs(8'h30, 2'h2, 5'h01, 1'b1);
		frame(`SFM_OP_SET_PARAM, 24'h310000, 1, 0, 0);
		frame(`SFM_OP_RST, 24'h0, 0, 0, 0);
		rs(8'h31, 2'h0, 5'h01, 1'b1);
		chk_word({31'h0, aborted}, 32'h0);
		frame(`SFM_OP_RST_EN, 24'h0, 0, 0, 0);
		frame(`SFM_OP_RST, 24'h0, 0, 0, 0);
		host.quad = 1'b0;
		chk_word({31'h0, aborted}, 32'h1);
		rs(8'h00, 2'h1, 5'h01, 1'b0);
		apb(1'b0, `SFM_REG_CTRL, 32'h0);
		chk_word(q, 32'h1);
		drove = 1'b0;
		frame(`SFM_OP_SEC_RD, 24'h0010ff, 3, 8, 1);
		chk_word({31'h0, drove}, 32'h0);
		rs(8'h00, 2'h0, 5'h01, 1'b0);
		$display("test soft_reset done");
		apb(1'b1, `SFM_REG_CTRL, 32'h9);
		host.open_frame();
		host.xfer(`SFM_OP_UDPD, 8, r);
		host.xfer(8'h00, 3, r);
		host.close_frame();
		rs(8'h00, 2'h0, 5'h01, 1'b0);
		apb(1'b1, `SFM_REG_CTRL, 32'h9);
		op_busy <= 1'b1;
		frame(`SFM_OP_UDPD, 24'h0, 0, 0, 0);
		op_busy <= 1'b0;
		rs(8'h00, 2'h0, 5'h02, 1'b0);
		frame(`SFM_OP_UDPD, 24'ha50000, 1, 0, 0);
		rs(8'h00, 2'h0, 5'h04, 1'b0);
		repeat (620) @(posedge clock);
		rs(8'h00, 2'h0, 5'h08, 1'b0);
		drove = 1'b0;
		frame(`SFM_OP_SEC_RD, 24'h0010ff, 3, 8, 1);
		chk_word({31'h0, drove}, 32'h0);
		frame(`SFM_OP_QUAD_ON, 24'h0, 0, 0, 0);
		rs(8'h00, 2'h0, 5'h10, 1'b0);
		repeat (2010) @(posedge clock);
		frame(`SFM_OP_QUAD_ON, 24'h0, 0, 0, 0);
		rs(8'h00, 2'h0, 5'h01, 1'b1);
		$display("test power_down done");
		tally_and_finish();
	end
endmodule // tb_top
